/* design/system_wake_event_controller.sv */
// Wake event controller: gathers wake sources, raises a power-up request.
// Assumes standby clk at 200 MHz; pin inputs are asynchronous.
`timescale 1ns/100ps
`default_nettype none
`include "wake_defines.svh"

module system_wake_event_controller
	import wake_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic acpi_mode,
	input wire sleep_t sleep_state,
	input wire logic conn_wake_pin,
	input wire logic pme_n_pin,
	input wire logic lan_wake_pin,
	input wire logic ring_pin,
	input wire logic usb_act_pin,
	input wire logic kbd_act_pin,
	input wire logic button_pin,
	input wire logic lan_wake_en,
	input wire logic s5_power_on_cfg,
	input wire logic cfg_load,
	input wire logic modem_irq_unmasked,
	input wire logic led_dual_colour,
	input wire logic power_ack,
	output logic power_up_req,
	output led_t front_led,
	output logic supply_on,
	output logic fans_on,
	output logic resume_from_s3,
	output src_t wake_cause
);
	localparam int NSYNC = `SRC_N;
	logic [NSYNC-1:0] sync1;
	logic [NSYNC-1:0] sync2;
	logic [NSYNC-1:0] prev;
	logic s5_wake_en;
	logic was_s3;
	wake_state_e state;
	wake_state_e next_state;
	wire logic [NSYNC-1:0] raw;
	wire logic [NSYNC-1:0] rise;
	wire logic is_apm;
	wire logic is_s1;
	wire logic is_s3;
	wire logic is_s5;
	wire logic any_hit;
	wake_src_if src ();

	// Raw pin vector; power event is active low
	assign raw = {button_pin, kbd_act_pin, usb_act_pin, ring_pin,
		lan_wake_pin, ~pme_n_pin, conn_wake_pin};

	// Two-stage synchroniser
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= raw;
			sync2 <= sync1;
		end
	end

	// Edge history for single-event detection
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			prev <= '0;
		else
			prev <= sync2;
	end
	assign rise = sync2 & ~prev;

	// State decode
	assign is_apm = sleep_state == `SLP_APM;
	assign is_s1 = sleep_state == `SLP_S1;
	assign is_s3 = sleep_state == `SLP_S3;
	assign is_s5 = sleep_state == `SLP_S5;

	// Soft-off wake enable, cleared by reset, loaded by configuration
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			s5_wake_en <= 1'b0;
		else if (cfg_load)
			s5_wake_en <= s5_power_on_cfg;
	end

	wake_gate gate (
		.is_apm(is_apm),
		.is_s1(is_s1),
		.is_s3(is_s3),
		.is_s5(is_s5),
		.acpi_mode(acpi_mode),
		.conn_wake(rise[`SRC_CONN]),
		.pme_evt(sync2[`SRC_PME]),
		.lan_evt(rise[`SRC_LAN]),
		.ring_evt(rise[`SRC_RING]),
		.usb_evt(rise[`SRC_USB]),
		.kbd_evt(rise[`SRC_KBD]),
		.button_evt(rise[`SRC_BUTTON]),
		.lan_en(lan_wake_en),
		.s5_wake_en(s5_wake_en),
		.modem_irq_unmasked(modem_irq_unmasked),
		.src(src)
	);
	assign any_hit = |src.hit;

	// Request sequencer: IDLE -> REQ until ack -> DONE until awake
	always_comb begin
		next_state = state;
		case (state)
			IDLE: if (any_hit) next_state = REQ;
			REQ: if (power_ack) next_state = DONE;
			DONE: if (sleep_state == `SLP_WORK) next_state = IDLE;
			default: next_state = IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			state <= IDLE;
		else
			state <= next_state;
	end

	// Cause and S3 origin latched on request start; cause also collects new hits while in REQ
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wake_cause <= '0;
			was_s3 <= 1'b0;
		end else if (state == IDLE && any_hit) begin
			wake_cause <= src.hit;
			was_s3 <= is_s3;
		end else if (state == REQ) begin
			wake_cause <= wake_cause | src.hit;
		end
	end

	assign power_up_req = state == REQ;
	assign resume_from_s3 = was_s3 && state != IDLE;

	// Supply, fans and indicator
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			supply_on <= 1'b0;
			fans_on <= 1'b0;
			front_led <= `LED_OFF;
		end else if (is_s3) begin
			supply_on <= 1'b0;
			fans_on <= 1'b0;
			front_led <= led_dual_colour ? `LED_AMBER : `LED_OFF;
		end else begin
			supply_on <= sleep_state == `SLP_WORK || is_s1 || is_apm;
			fans_on <= sleep_state == `SLP_WORK;
			front_led <= sleep_state == `SLP_WORK ? `LED_GREEN : `LED_OFF;
		end
	end

	// Checks
	property p_req_hold;
		@(posedge clk) disable iff (!nrst)
		power_up_req && !power_ack |=> power_up_req;
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("request dropped");

	property p_s3_led;
		@(posedge clk) disable iff (!nrst)
		is_s3 && !led_dual_colour |=> front_led == `LED_OFF && !supply_on;
	endproperty
	a_s3_led: assert property (p_s3_led) else $error("s3 led wrong");

	property p_s3_amber;
		@(posedge clk) disable iff (!nrst)
		is_s3 && led_dual_colour |=> front_led == `LED_AMBER && !fans_on;
	endproperty
	a_s3_amber: assert property (p_s3_amber) else $error("s3 amber wrong");

	property p_conn_apm;
		@(posedge clk) disable iff (!nrst)
		src.hit[`SRC_CONN] |-> !acpi_mode && is_apm;
	endproperty
	a_conn_apm: assert property (p_conn_apm) else $error("conn not apm");

	property p_ring;
		@(posedge clk) disable iff (!nrst)
		src.hit[`SRC_RING] |-> modem_irq_unmasked && !is_s3 && !is_s5;
	endproperty
	a_ring: assert property (p_ring) else $error("ring gating wrong");

	property p_lan;
		@(posedge clk) disable iff (!nrst)
		src.hit[`SRC_LAN] |-> acpi_mode && lan_wake_en;
	endproperty
	a_lan: assert property (p_lan) else $error("lan gating wrong");

	property p_usb;
		@(posedge clk) disable iff (!nrst)
		state == IDLE && acpi_mode && is_s3 && rise[`SRC_USB]
			|=> power_up_req;
	endproperty
	a_usb: assert property (p_usb) else $error("usb no wake");

	property p_kbd;
		@(posedge clk) disable iff (!nrst)
		state == IDLE && acpi_mode && is_s1 && rise[`SRC_KBD]
			|=> power_up_req;
	endproperty
	a_kbd: assert property (p_kbd) else $error("kbd no wake");

	property p_s5;
		@(posedge clk) disable iff (!nrst)
		is_s5 && !s5_wake_en |-> !src.hit[`SRC_PME] && !src.hit[`SRC_LAN];
	endproperty
	a_s5: assert property (p_s5) else $error("s5 wake leaked");
endmodule

`default_nettype wire

/* design/wake_defines.svh */
// Constants for the system wake event controller.
// Assumes inclusion by bare name from design files.
`ifndef WAKE_DEFINES_SVH
`define WAKE_DEFINES_SVH

// Sleep state encoding on the state input
`define SLP_WORK 3'h0
`define SLP_APM 3'h1
`define SLP_S1 3'h2
`define SLP_S3 3'h3
`define SLP_S5 3'h4

// Front indicator colour codes
`define LED_OFF 2'h0
`define LED_GREEN 2'h1
`define LED_AMBER 2'h2

// Number of wake sources and their bit positions
`define SRC_N 7
`define SRC_CONN 0
`define SRC_PME 1
`define SRC_LAN 2
`define SRC_RING 3
`define SRC_USB 4
`define SRC_KBD 5
`define SRC_BUTTON 6

`endif

/* design/wake_pkg.sv */
// Types for the system wake event controller.
// Assumes the defines header is available.
`include "wake_defines.svh"

package wake_pkg;
	typedef logic [2:0] sleep_t;
	typedef logic [1:0] led_t;
	typedef logic [`SRC_N-1:0] src_t;
	typedef enum logic [1:0] {IDLE, REQ, DONE} wake_state_e;
endpackage

/* design/wake_src_if.sv */
// Carrier of qualified wake sources between the gate and the top.
// Assumes both ends run on clk.
`timescale 1ns/100ps
`default_nettype none

interface wake_src_if;
	import wake_pkg::*;
	src_t hit;
	modport gate (output hit);
	modport top (input hit);
endinterface

`default_nettype wire

/* design/wake_gate.sv */
// Qualifies synchronised wake inputs by sleep state and enables.
// Assumes all inputs are already on clk.
`timescale 1ns/100ps
`default_nettype none
`include "wake_defines.svh"

module wake_gate
	import wake_pkg::*;
(
	input wire logic is_apm,
	input wire logic is_s1,
	input wire logic is_s3,
	input wire logic is_s5,
	input wire logic acpi_mode,
	input wire logic conn_wake,
	input wire logic pme_evt,
	input wire logic lan_evt,
	input wire logic ring_evt,
	input wire logic usb_evt,
	input wire logic kbd_evt,
	input wire logic button_evt,
	input wire logic lan_en,
	input wire logic s5_wake_en,
	input wire logic modem_irq_unmasked,
	wake_src_if.gate src
);
	wire logic acpi_sleep;
	wire logic s5_ok;
	wire logic hit_conn;
	wire logic hit_pme;
	wire logic hit_lan;
	wire logic hit_ring;
	wire logic hit_usb;
	wire logic hit_kbd;
	wire logic hit_button;

	// ACPI sleep states where most sources act
	assign acpi_sleep = acpi_mode && (is_s1 || is_s3);
	assign s5_ok = acpi_mode && is_s5 && s5_wake_en;

	// Per-source qualification
	assign hit_conn = conn_wake && !acpi_mode && is_apm;
	assign hit_pme = pme_evt && (acpi_sleep || s5_ok);
	assign hit_lan = lan_evt && lan_en
		&& (acpi_sleep || s5_ok);
	assign hit_ring = ring_evt && modem_irq_unmasked
		&& ((is_apm && !acpi_mode) || (acpi_mode && is_s1));
	assign hit_usb = usb_evt && acpi_sleep;
	assign hit_kbd = kbd_evt && acpi_sleep;
	assign hit_button = button_evt
		&& (acpi_sleep || (acpi_mode && is_s5) || is_apm);

	// One driver for the whole vector, bit 0 is the connector source
	assign src.hit = {hit_button, hit_kbd, hit_usb, hit_ring, hit_lan,
		hit_pme, hit_conn};
endmodule

`default_nettype wire

/* verif/wake_source_model.sv */
// Far-side wake sources: connector, power event, network, modem, USB, keyboard, button.
// Assumes fire bits arrive as one-cycle pulses on clk.
`timescale 1ns/100ps
`default_nettype none
`include "wake_defines.svh"

module wake_source_model
	import wake_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire src_t fire,
	output logic conn_wake_pin,
	output logic pme_n_pin,
	output logic lan_wake_pin,
	output logic ring_pin,
	output logic usb_act_pin,
	output logic kbd_act_pin,
	output logic button_pin
);
	logic [1:0] hold [`SRC_N];
	// Each source holds its line for three cycles, long enough to sync
	always_ff @(posedge clk or negedge nrst) begin
		for (int i = 0; i < `SRC_N; i++) begin
			if (!nrst)
				hold[i] <= 2'h0;
			else if (fire[i])
				hold[i] <= 2'h3;
			else if (hold[i] != 2'h0)
				hold[i] <= hold[i] - 2'h1;
		end
	end
	// Wake lines; power event is active low
	assign conn_wake_pin = hold[`SRC_CONN] != 2'h0;
	assign pme_n_pin = hold[`SRC_PME] == 2'h0;
	assign lan_wake_pin = hold[`SRC_LAN] != 2'h0;
	assign ring_pin = hold[`SRC_RING] != 2'h0;
	assign usb_act_pin = hold[`SRC_USB] != 2'h0;
	assign kbd_act_pin = hold[`SRC_KBD] != 2'h0;
	assign button_pin = hold[`SRC_BUTTON] != 2'h0;
endmodule

`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench for the wake event controller.
// Assumes the source model stands on the far side of the pins.
`timescale 1ns/100ps
`default_nettype none
`include "wake_defines.svh"

module testbench;
	import wake_pkg::*;
	logic clk = 0, nrst = 0, acpi_mode = 0, s5_power_on_cfg = 0;
	logic cfg_load = 0, lan_wake_en = 0, modem_irq_unmasked = 0;
	logic led_dual_colour = 0, power_ack = 0, s5_loaded = 0;
	logic conn, pme_n, lan, ring, usb, kbd, btn, power_up_req;
	logic supply_on, fans_on, resume_from_s3;
	sleep_t sleep_state = 3'h0;
	src_t fire = '0, wake_cause;
	led_t front_led;
	logic [31:0] rnd = 32'h6e324269;
	int err_total = 0, checked = 0;
	logic flip_acpi = 0;
	src_t cause_exp = '0;
	typedef struct {string name; logic [6:0] val;} note_s;
	note_s notes[$];
	note_s cur;
	event sample;

	always #2.5 clk = ~clk;

	wake_source_model wake_source_model_inst (.clk(clk), .nrst(nrst),
		.fire(fire), .conn_wake_pin(conn), .pme_n_pin(pme_n),
		.lan_wake_pin(lan), .ring_pin(ring), .usb_act_pin(usb),
		.kbd_act_pin(kbd), .button_pin(btn));
	system_wake_event_controller system_wake_event_controller_inst (
		.clk(clk), .nrst(nrst), .acpi_mode(acpi_mode),
		.sleep_state(sleep_state), .conn_wake_pin(conn),
		.pme_n_pin(pme_n), .lan_wake_pin(lan), .ring_pin(ring),
		.usb_act_pin(usb), .kbd_act_pin(kbd), .button_pin(btn),
		.lan_wake_en(lan_wake_en), .s5_power_on_cfg(s5_power_on_cfg),
		.cfg_load(cfg_load), .modem_irq_unmasked(modem_irq_unmasked),
		.led_dual_colour(led_dual_colour), .power_ack(power_ack),
		.power_up_req(power_up_req), .front_led(front_led),
		.supply_on(supply_on), .fans_on(fans_on),
		.resume_from_s3(resume_from_s3), .wake_cause(wake_cause));

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	// Which source may wake from which state, a is the ACPI flag
	function automatic logic wakes(logic [2:0] st, int s, logic en,
		logic msk, logic a);
		logic slp, off, apm;
		apm = st == `SLP_APM;
		slp = a && (st == `SLP_S1 || st == `SLP_S3);
		off = a && st == `SLP_S5 && s5_loaded;
		case (s)
			0: wakes = apm && !a;
			1: wakes = slp || off;
			2: wakes = en && (slp || off);
			3: wakes = msk && ((apm && !a) || (a && st == `SLP_S1));
			4, 5: wakes = slp;
			6: wakes = slp || (a && st == `SLP_S5) || apm;
			default: wakes = 1'b0;
		endcase
	endfunction

	task automatic note(input string n, input logic [6:0] v);
		notes.push_back('{n, v});
		->sample;
	endtask

	// Count a comparison, report a mismatch
	task automatic tally(input string n, input logic [6:0] e, g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic compare_req(input logic [6:0] e);
		tally("power_up_req", e, {6'h0, power_up_req});
	endtask
	task automatic compare_cause(input logic [6:0] e);
		tally("wake_cause", e, wake_cause);
	endtask
	task automatic compare_resume(input logic [6:0] e);
		tally("resume_from_s3", e, {6'h0, resume_from_s3});
	endtask
	task automatic compare_power(input logic [6:0] e);
		tally("led_supply_fans", e, {3'h0, front_led, supply_on, fans_on});
	endtask

	// Monitor takes each pending note, oldest first, and compares it
	always @(sample) begin
		while (notes.size() > 0) begin
			cur = notes.pop_front();
			case (cur.name)
				"req": compare_req(cur.val);
				"cause": compare_cause(cur.val);
				"resume": compare_resume(cur.val);
				default: compare_power(cur.val);
			endcase
		end
	end

	task automatic trial(input logic [2:0] st, input int src,
		input logic en, input logic msk, input logic dual);
		logic w, a;
		logic [6:0] pwr;
		a = (st != `SLP_APM) ^ flip_acpi;
		w = wakes(st, src, en, msk, a);
		// Cause register keeps the last wake until a new one starts
		if (w)
			cause_exp = src_t'(1) << src;
		pwr[6:4] = 3'h0;
		pwr[3:2] = st == `SLP_S3 ? (dual ? `LED_AMBER : `LED_OFF)
			: (st == `SLP_WORK ? `LED_GREEN : `LED_OFF);
		pwr[1] = st == `SLP_WORK || st == `SLP_S1 || st == `SLP_APM;
		pwr[0] = st == `SLP_WORK;
		@(posedge clk);
		sleep_state <= st;
		acpi_mode <= a;
		lan_wake_en <= en;
		modem_irq_unmasked <= msk;
		led_dual_colour <= dual;
		repeat (3) @(posedge clk);
		#1;
		note("power", pwr);
		@(posedge clk);
		fire <= src_t'(1) << src;
		@(posedge clk);
		fire <= '0;
		repeat (7) @(posedge clk);
		#1;
		note("req", {6'h0, w});
		note("cause", cause_exp);
		note("resume", {6'h0, w && st == `SLP_S3});
		if (w) begin
			rnd = xs(rnd);
			repeat (rnd[1:0]) @(posedge clk);
			#1;
			note("req", 7'h1);
			@(posedge clk);
			power_ack <= 1'b1;
			@(posedge clk);
			power_ack <= 1'b0;
			@(posedge clk);
			#1;
			note("req", 7'h0);
		end
		@(posedge clk);
		sleep_state <= `SLP_WORK;
		repeat (3) @(posedge clk);
	endtask

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Watchdog, more than ten times the expected length of the run
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		stop_test();
	end

	// Main sequence
	initial begin
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		s5_power_on_cfg <= 1'b1;
		repeat (3) @(posedge clk);
		trial(`SLP_S5, 1, 1, 1, 0);
		trial(`SLP_S5, 2, 1, 1, 0);
		@(posedge clk);
		cfg_load <= 1'b1;
		@(posedge clk);
		cfg_load <= 1'b0;
		s5_loaded = 1'b1;
		trial(`SLP_S1, 3, 1, 0, 0);
		for (int st = 0; st < 5; st++)
			for (int s = 0; s < 7; s++)
				trial(st[2:0], s, 1, 1, st[0]);
		repeat (40) begin
			rnd = xs(rnd);
			flip_acpi = rnd[11];
			trial(rnd[2:0] % 5, rnd[7:4] % 7, rnd[8], rnd[9], rnd[10]);
		end
		flip_acpi = 1'b0;
		// Mid-run reset must drop the soft-off wake enable again
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		s5_loaded = 1'b0;
		cause_exp = '0;
		repeat (3) @(posedge clk);
		trial(`SLP_S5, 1, 1, 1, 0);
		trial(`SLP_S5, 2, 1, 1, 0);
		stop_test();
	end
endmodule

`default_nettype wire
